// ### verilog/printer_pen_retrace_consts.vh
// Constants for the printer, light-pen and retrace adapter port.
// Assumes inclusion by bare name; definitions only.
`ifndef PRINTER_PEN_RETRACE_CONSTS_VH
`define PRINTER_PEN_RETRACE_CONSTS_VH

// Register select codes
`define RS_PORTA        2'h0
`define RS_CTRLA        2'h1
`define RS_PORTB        2'h2
`define RS_CTRLB        2'h3

// Control register field positions and register reset values
`define CTL_C1_EN       0
`define CTL_C1_RISE     1
`define CTL_DATA_SEL    2
`define CTL_C2_EN       3
`define CTL_C2_RISE     4
`define CTL_FLAG2       6
`define CTL_FLAG1       7
`define CTL_RESET       6'h00
`define DATA_RESET      8'h00
`define DIR_RESET       8'h00

// Port A bit positions
`define PA_BUSY         0
`define PA_ERROR        1
`define PA_INIT         4
`define PA_RETRACE_CLR  5
`define PA_PEN_SW       6
`define PA_PEN_CLR      7

// Timing
`define CLK_PERIOD_NS   20
`define STROBE_NS       1000
`define STROBE_CYCLES   ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verilog/edge_pulse.v
// Programmable edge detector: one-cycle pulse on the selected transition.
// Assumes its input is synchronous to core_clk.
module edge_pulse (
    input  wire core_clk,
    input  wire rst_n,
    input  wire level,
    input  wire riseSel,
    output wire pulse
);
    reg prev_reg;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level;
        end
    end

    assign pulse = riseSel ? (level & ~prev_reg) : (~level & prev_reg);
endmodule // edge_pulse

// ### verilog/printer_pen_retrace_port.v
// Adapter-based parallel port: printer output, light-pen and retrace latches.
// Assumes all inputs synchronous to core_clk; the host keeps its own protocol.
//
// Function
// - Chip select plus two select bits pick one adapter register per access.
// - Bus accesses take effect only while the enable clock phase is high.
// - Write when direction line is set and write strobe pulses; read when it is clear and read strobe is high.
// - Printer byte appears on port B bits on the same edge that strobe goes low.
// - Inverted acknowledge drives control input B1 with selectable edge polarity.
// - A detected acknowledge transition raises the printer interrupt.
// - Busy drives control input B2 and a port A bit; edge raises interrupt.
// - Jumper selects leading or trailing pen pulse edge for the pen latch.
// - Pen pulse sets pen latch; latch drives display controller pen strobe.
// - Rising pen latch at control input A1 drives port A interrupt low.
// - Vertical sync rising edge sets retrace latch, raising display interrupt.
//
// Chosen here: the address-and-strobe port and the address map.
`include "printer_pen_retrace_consts.vh"

module printer_pen_retrace_port #(
    parameter STROBE_LEN = `STROBE_CYCLES
) (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       ePhaseClock,
    input  wire       adapterChipSelectN,
    input  wire       regSelectBit0,
    input  wire       regSelectBit1,
    input  wire       dirWrite,
    input  wire       writeStrobeN,
    input  wire       busReadStrobe,
    input  wire [7:0] writeData,
    output wire [7:0] readData,
    output wire [7:0] printerOutBits,
    output wire       printerStrobeN,
    input  wire       printerAck,
    input  wire       busyBuffered,
    input  wire       printerErrorN,
    input  wire       penPulse,
    input  wire       penEdgeJumper,
    input  wire       penSwitchIn,
    input  wire       verticalSyncBuffered,
    input  wire [7:0] portaIn,
    output wire [7:0] portaOut,
    output wire [7:0] portaDir,
    output wire       penStrobe,
    output wire       portaIrqN,
    output wire       portbIrqN,
    output wire       irq
);
    reg [7:0] readData_reg;
    reg [7:0] portaData_reg;
    reg [7:0] portaDir_reg;
    reg [7:0] portbData_reg;
    reg [7:0] portbDir_reg;
    reg [5:0] ctrlA_reg;
    reg [5:0] ctrlB_reg;
    reg       flagA1_reg;
    reg       flagA2_reg;
    reg       flagB1_reg;
    reg       flagB2_reg;
    reg       penLatch_reg;
    reg       retraceLatch_reg;
    reg       strobeN_reg;
    reg [15:0] strobeCnt_reg;

    wire [1:0] regSel;
    wire       selected;
    wire       wrAccess;
    wire       rdAccess;
    wire [3:0] ctrlLevel;
    wire [3:0] ctrlRise;
    wire [3:0] ctrlEdge;
    wire       penEdge;
    wire       vsyncEdge;
    wire [7:0] portaPins;
    wire [7:0] portaEff;
    wire       rdPortA;
    wire       rdPortB;
    wire       wrPortBData;
    wire       wrCtrlA;
    wire       wrCtrlB;
    wire [3:0] flagClr;
    reg  [7:0] readNext;

    // True when the access addresses the data register rather than direction
    function isData;
        input [1:0] sel;
        input [5:0] ctl;
        input [1:0] target;
        begin
            isData = (sel == target) && ctl[`CTL_DATA_SEL];
        end
    endfunction

    // Flag clear: a data read, or a one written to the flag's control bit
    function flagClear;
        input rdPort;
        input wrCtrl;
        input w1cBit;
        begin
            flagClear = rdPort | (wrCtrl & w1cBit);
        end
    endfunction

    // Control register view: flags read back above the writable fields
    function [7:0] ctrlView;
        input       flag1;
        input       flag2;
        input [5:0] ctl;
        begin
            ctrlView = {flag1, flag2, ctl};
        end
    endfunction

    // Interrupt request of one port: a flag counts only while enabled
    function irqActive;
        input       flag1;
        input       flag2;
        input [5:0] ctl;
        begin
            irqActive = (flag1 & ctl[`CTL_C1_EN]) | (flag2 & ctl[`CTL_C2_EN]);
        end
    endfunction

    assign regSel   = {regSelectBit1, regSelectBit0};
    assign selected = ~adapterChipSelectN & ePhaseClock;
    assign wrAccess = selected & dirWrite & ~writeStrobeN;
    assign rdAccess = selected & ~dirWrite & busReadStrobe;

    assign rdPortA     = rdAccess & isData(regSel, ctrlA_reg, `RS_PORTA);
    assign rdPortB     = rdAccess & isData(regSel, ctrlB_reg, `RS_PORTB);
    assign wrPortBData = wrAccess & isData(regSel, ctrlB_reg, `RS_PORTB);
    assign wrCtrlA     = wrAccess & (regSel == `RS_CTRLA);
    assign wrCtrlB     = wrAccess & (regSel == `RS_CTRLB);

    // Flag order matches ctrlEdge: A1, A2, B1, B2
    assign flagClr[0] = flagClear(rdPortA, wrCtrlA, writeData[`CTL_FLAG1]);
    assign flagClr[1] = flagClear(rdPortA, wrCtrlA, writeData[`CTL_FLAG2]);
    assign flagClr[2] = flagClear(rdPortB, wrCtrlB, writeData[`CTL_FLAG1]);
    assign flagClr[3] = flagClear(rdPortB, wrCtrlB, writeData[`CTL_FLAG2]);

    // Undriven port A lines float high, so a clear line only acts when driven low
    assign portaEff = (portaData_reg & portaDir_reg) | ~portaDir_reg;

    // Control inputs: A1 pen latch, A2 retrace latch, B1 inverted ack, B2 busy
    assign ctrlLevel = {busyBuffered, ~printerAck, retraceLatch_reg, penLatch_reg};
    assign ctrlRise  = {ctrlB_reg[`CTL_C2_RISE], ctrlB_reg[`CTL_C1_RISE],
                        ctrlA_reg[`CTL_C2_RISE], ctrlA_reg[`CTL_C1_RISE]};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : ctrlDetect
            edge_pulse ctrlEdgeDet (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .level    (ctrlLevel[gi]),
                .riseSel  (ctrlRise[gi]),
                .pulse    (ctrlEdge[gi])
            );
        end
    endgenerate

    edge_pulse penEdgeDet (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .level    (penPulse),
        .riseSel  (penEdgeJumper),
        .pulse    (penEdge)
    );

    edge_pulse vsyncEdgeDet (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .level    (verticalSyncBuffered),
        .riseSel  (1'b1),
        .pulse    (vsyncEdge)
    );

    // Latches: a new edge wins over a clear held in the same cycle
    always @(posedge core_clk) begin
        if (!rst_n) begin
            penLatch_reg     <= 1'b0;
            retraceLatch_reg <= 1'b0;
        end else begin
            if (penEdge) begin
                penLatch_reg <= 1'b1;
            end else if (!portaEff[`PA_PEN_CLR]) begin
                penLatch_reg <= 1'b0;
            end
            if (vsyncEdge) begin
                retraceLatch_reg <= 1'b1;
            end else if (!portaEff[`PA_RETRACE_CLR]) begin
                retraceLatch_reg <= 1'b0;
            end
        end
    end

    // Interrupt flags: set by control edges, cleared by data read or by
    // writing a one to the flag bit; set beats clear in the same cycle
    always @(posedge core_clk) begin
        if (!rst_n) begin
            flagA1_reg <= 1'b0;
            flagA2_reg <= 1'b0;
            flagB1_reg <= 1'b0;
            flagB2_reg <= 1'b0;
        end else begin
            if (ctrlEdge[0]) begin
                flagA1_reg <= 1'b1;
            end else if (flagClr[0]) begin
                flagA1_reg <= 1'b0;
            end
            if (ctrlEdge[1]) begin
                flagA2_reg <= 1'b1;
            end else if (flagClr[1]) begin
                flagA2_reg <= 1'b0;
            end
            if (ctrlEdge[2]) begin
                flagB1_reg <= 1'b1;
            end else if (flagClr[2]) begin
                flagB1_reg <= 1'b0;
            end
            if (ctrlEdge[3]) begin
                flagB2_reg <= 1'b1;
            end else if (flagClr[3]) begin
                flagB2_reg <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge core_clk) begin
        if (!rst_n) begin
            portaData_reg <= `DATA_RESET;
            portaDir_reg  <= `DIR_RESET;
            portbData_reg <= `DATA_RESET;
            portbDir_reg  <= `DIR_RESET;
            ctrlA_reg     <= `CTL_RESET;
            ctrlB_reg     <= `CTL_RESET;
        end else if (wrAccess) begin
            case (regSel)
                `RS_PORTA: begin
                    if (ctrlA_reg[`CTL_DATA_SEL]) begin
                        portaData_reg <= writeData;
                    end else begin
                        portaDir_reg <= writeData;
                    end
                end
                `RS_CTRLA: begin
                    ctrlA_reg <= writeData[5:0];
                end
                `RS_PORTB: begin
                    if (ctrlB_reg[`CTL_DATA_SEL]) begin
                        portbData_reg <= writeData;
                    end else begin
                        portbDir_reg <= writeData;
                    end
                end
                `RS_CTRLB: begin
                    ctrlB_reg <= writeData[5:0];
                end
                default: begin
                    ctrlB_reg <= ctrlB_reg;
                end
            endcase
        end
    end

    // Strobe goes low on the same edge that stores the byte, so data does not lead it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            strobeN_reg   <= 1'b1;
            strobeCnt_reg <= 16'h0000;
        end else if (wrPortBData) begin
            strobeN_reg   <= 1'b0;
            strobeCnt_reg <= STROBE_LEN[15:0];
        end else if (strobeCnt_reg > 16'h0001) begin
            strobeCnt_reg <= strobeCnt_reg - 16'h0001;
        end else begin
            strobeN_reg   <= 1'b1;
            strobeCnt_reg <= 16'h0000;
        end
    end

    // Port A pins read back: inputs where not driven, busy, error and switch fixed
    assign portaPins = {portaIn[7], ~penSwitchIn, portaIn[5:2],
                        printerErrorN, busyBuffered};

    always @* begin
        readNext = 8'h00;
        case (regSel)
            `RS_PORTA: begin
                if (ctrlA_reg[`CTL_DATA_SEL]) begin
                    readNext = (portaData_reg & portaDir_reg) | (portaPins & ~portaDir_reg);
                end else begin
                    readNext = portaDir_reg;
                end
            end
            `RS_CTRLA: begin
                readNext = ctrlView(flagA1_reg, flagA2_reg, ctrlA_reg);
            end
            `RS_PORTB: begin
                if (ctrlB_reg[`CTL_DATA_SEL]) begin
                    readNext = portbData_reg;
                end else begin
                    readNext = portbDir_reg;
                end
            end
            `RS_CTRLB: begin
                readNext = ctrlView(flagB1_reg, flagB2_reg, ctrlB_reg);
            end
            default: begin
                readNext = 8'h00;
            end
        endcase
    end

    // Read data stands only in the cycle after the read strobe
    always @(posedge core_clk) begin
        if (!rst_n) begin
            readData_reg <= 8'h00;
        end else if (rdAccess) begin
            readData_reg <= readNext;
        end else begin
            readData_reg <= 8'h00;
        end
    end

    assign readData       = readData_reg;
    assign printerOutBits = portbData_reg;
    assign printerStrobeN = strobeN_reg;
    assign portaOut       = portaData_reg;
    assign portaDir       = portaDir_reg;
    assign penStrobe      = penLatch_reg;
    assign portaIrqN      = ~irqActive(flagA1_reg, flagA2_reg, ctrlA_reg);
    assign portbIrqN      = ~irqActive(flagB1_reg, flagB2_reg, ctrlB_reg);
    assign irq            = ~portaIrqN | ~portbIrqN;
endmodule // printer_pen_retrace_port

// ### tb/printer_pen_retrace_port_checker.sv
// Assertions on the adapter port's pins.
// Assumes binding to printer_pen_retrace_port; sees only its ports.
module printer_pen_retrace_port_checker #(
    parameter int STROBE_LEN = 50
) (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       ePhaseClock,
    input wire logic       adapterChipSelectN,
    input wire logic       regSelectBit0,
    input wire logic       regSelectBit1,
    input wire logic       dirWrite,
    input wire logic       writeStrobeN,
    input wire logic       busReadStrobe,
    input wire logic [7:0] readData,
    input wire logic [7:0] printerOutBits,
    input wire logic       printerStrobeN,
    input wire logic       penPulse,
    input wire logic       penEdgeJumper,
    input wire logic [7:0] portaOut,
    input wire logic [7:0] portaDir,
    input wire logic       penStrobe,
    input wire logic       portaIrqN,
    input wire logic       portbIrqN,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    wire        live = !adapterChipSelectN && ePhaseClock;
    wire        acc  = live && (busReadStrobe || !writeStrobeN);
    wire        rdT  = live && !dirWrite && busReadStrobe;
    // Any port B write restarts the count; direction writes mid-strobe would mislead it
    wire        wrB  = live && dirWrite && !writeStrobeN && regSelectBit1 && !regSelectBit0;
    logic [7:0] lowCnt;

    always @(posedge core_clk) begin
        if (!rst_n || wrB || printerStrobeN)
            lowCnt <= 8'h00;
        else
            lowCnt <= lowCnt + 8'h01;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_read_idle: assert property (!$past(rdT) |-> readData == 8'h00)
        else $error("read data outside its slot");
    a_strobe_cause: assert property ($fell(printerStrobeN) |-> $past(wrB))
        else $error("strobe fell without a port B write");
    a_strobe_width: assert property ($rose(printerStrobeN) |-> lowCnt == STROBE_LEN)
        else $error("strobe width wrong");
    a_bits_cause: assert property (!$stable(printerOutBits) |-> $past(wrB))
        else $error("printer byte changed without a write");
    a_irq_merge: assert property (irq == (!portaIrqN || !portbIrqN))
        else $error("irq does not follow port interrupts");
    a_pen_lead: assert property ($rose(penPulse) && penEdgeJumper |-> ##[0:2] penStrobe)
        else $error("pen latch missed leading edge");
    a_pen_trail: assert property ($fell(penPulse) && !penEdgeJumper |-> ##[0:2] penStrobe)
        else $error("pen latch missed trailing edge");
    a_pen_hold: assert property (penStrobe && !(portaDir[7] && !portaOut[7]) |=> penStrobe)
        else $error("pen latch dropped without clear");
    a_irqb_hold: assert property (!portbIrqN && !acc |=> !portbIrqN)
        else $error("port B interrupt dropped without access");
    a_porta_irq_n_hold: assert property (!portaIrqN && !acc |=> !portaIrqN)
        else $error("port A interrupt dropped without access");
endmodule // printer_pen_retrace_port_checker

bind printer_pen_retrace_port printer_pen_retrace_port_checker #(.STROBE_LEN(STROBE_LEN)) chk_i (
    .core_clk, .rst_n, .ePhaseClock, .adapterChipSelectN, .regSelectBit0, .regSelectBit1,
    .dirWrite, .writeStrobeN, .busReadStrobe, .readData, .printerOutBits, .printerStrobeN,
    .penPulse, .penEdgeJumper, .portaOut, .portaDir, .penStrobe, .portaIrqN, .portbIrqN, .irq
);

// ### tb/printer_model.sv
// Behavioural parallel printer on the far side of the port.
// Assumes the strobe is shorter than the busy-then-acknowledge sequence.
module printer_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic printerStrobeN,
    output logic      printerAck,
    output logic      busyBuffered
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] phase;

    always @(posedge core_clk) begin
        if (!rst_n)
            phase <= 4'h0;
        else if (phase != 4'h0)
            phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
        else if (!printerStrobeN)
            phase <= 4'h1;
    end

    // Head moves first (busy), then acknowledge pulses low for four cycles
    assign busyBuffered = phase >= 4'h1 && phase <= 4'h5;
    assign printerAck   = !(phase >= 4'h7 && phase <= 4'hA);
endmodule // printer_model

// ### tb/printer_pen_retrace_port_tb.sv
// Self-checking bench for the printer, pen and retrace port.
// Assumes printer_model on the printer pins and the bound checker.
module printer_pen_retrace_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_n, ePhaseClock, adapterChipSelectN, regSelectBit0, regSelectBit1;
    logic dirWrite, writeStrobeN, busReadStrobe, printerStrobeN, printerAck, busyBuffered;
    logic printerErrorN, penPulse, penEdgeJumper, penSwitchIn, verticalSyncBuffered;
    logic penStrobe, portaIrqN, portbIrqN, irq, csOff, eOff;
    logic [7:0] writeData, readData, printerOutBits, portaIn, portaOut, portaDir, got;
    int fail_count = 0, n_compared = 0, cycles = 0, i;

    printer_pen_retrace_port #(.STROBE_LEN(3)) DUT (
        .core_clk, .rst_n, .ePhaseClock, .adapterChipSelectN, .regSelectBit0, .regSelectBit1,
        .dirWrite, .writeStrobeN, .busReadStrobe, .writeData, .readData, .printerOutBits,
        .printerStrobeN, .printerAck, .busyBuffered, .printerErrorN, .penPulse,
        .penEdgeJumper, .penSwitchIn, .verticalSyncBuffered, .portaIn, .portaOut, .portaDir,
        .penStrobe, .portaIrqN, .portbIrqN, .irq
    );
    printer_model prn (.core_clk, .rst_n, .printerStrobeN, .printerAck, .busyBuffered);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = !core_clk;
    end

    task automatic report_and_stop;
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access: strobe for one cycle, read data sampled in the cycle after
    task automatic bus(input logic w, input logic [1:0] s, input logic [7:0] d);
        @(posedge core_clk);
        adapterChipSelectN <= csOff;
        ePhaseClock <= !eOff;
        dirWrite <= w;
        writeStrobeN <= !w;
        busReadStrobe <= !w;
        {regSelectBit1, regSelectBit0} <= s;
        writeData <= d;
        @(posedge core_clk);
        adapterChipSelectN <= 1'b1;
        writeStrobeN <= 1'b1;
        busReadStrobe <= 1'b0;
        #1 got = readData;
    endtask

    task automatic waitAck(input logic v);
        for (i = 0; i < 50 && printerAck !== v; i++)
            @(posedge core_clk);
    endtask

    task automatic edges(input logic pen, input logic vs);
        @(posedge core_clk);
        penPulse <= pen;
        verticalSyncBuffered <= vs;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    initial begin
        {rst_n, adapterChipSelectN, ePhaseClock, writeStrobeN} = 4'b0111;
        {dirWrite, busReadStrobe, regSelectBit0, regSelectBit1, csOff, eOff} = 6'h00;
        {penPulse, verticalSyncBuffered, penSwitchIn, printerErrorN} = 4'h1;
        {writeData, portaIn, penEdgeJumper} = {8'h00, 8'h08, 1'b1};
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk({printerStrobeN, irq, readData}, 10'h200);
        csOff = 1'b1;
        bus(1'b1, 2'h3, 8'h1F);
        {csOff, eOff} = 2'b01;
        bus(1'b1, 2'h3, 8'h1F);
        eOff = 1'b0;
        bus(1'b0, 2'h3, 8'h00);
        chk(got, 8'h00);
        // Data first, then direction, so the initialize line never glitches low
        bus(1'b1, 2'h1, 8'h1F);
        bus(1'b1, 2'h0, 8'hB0);
        bus(1'b1, 2'h1, 8'h1B);
        bus(1'b1, 2'h0, 8'hB0);
        bus(1'b1, 2'h1, 8'h1F);
        bus(1'b1, 2'h0, 8'hA0);
        chk({portaDir, portaOut}, 16'hB0A0);
        bus(1'b1, 2'h0, 8'hB0);
        chk(portaOut, 8'hB0);
        bus(1'b1, 2'h3, 8'h1F);
        bus(1'b0, 2'h3, 8'h00);
        chk(got, 8'h1F);
        bus(1'b0, 2'h0, 8'h00);
        chk(got, 8'hFA);
        bus(1'b1, 2'h2, 8'hA5);
        chk({printerStrobeN, printerOutBits}, 9'h0A5);
        bus(1'b0, 2'h0, 8'h00);
        chk(got, 8'hFB);
        waitAck(1'b0);
        waitAck(1'b1);
        bus(1'b0, 2'h3, 8'h00);
        chk({irq, portbIrqN, got}, 10'h2DF);
        bus(1'b0, 2'h2, 8'h00);
        chk({portbIrqN, got}, 9'h1A5);
        bus(1'b1, 2'h3, 8'h1D);
        bus(1'b1, 2'h2, 8'h3C);
        waitAck(1'b0);
        bus(1'b0, 2'h3, 8'h00);
        chk(got[7], 1'b0);
        waitAck(1'b1);
        repeat (3) @(posedge core_clk);
        bus(1'b0, 2'h3, 8'h00);
        chk(got, 8'hDD);
        bus(1'b0, 2'h2, 8'h00);
        chk(got, 8'h3C);
        @(posedge core_clk);
        printerErrorN <= 1'b0;
        penSwitchIn <= 1'b1;
        bus(1'b0, 2'h0, 8'h00);
        chk(got, 8'hB8);
        @(posedge core_clk);
        printerErrorN <= 1'b1;
        penSwitchIn <= 1'b0;
        edges(1'b1, 1'b0);
        chk({penStrobe, portaIrqN}, 2'b10);
        bus(1'b0, 2'h1, 8'h00);
        chk(got, 8'h9F);
        bus(1'b0, 2'h0, 8'h00);
        chk(portaIrqN, 1'b1);
        bus(1'b1, 2'h0, 8'h30);
        bus(1'b1, 2'h0, 8'hB0);
        chk(penStrobe, 1'b0);
        penEdgeJumper <= 1'b0;
        edges(1'b1, 1'b0);
        chk(penStrobe, 1'b0);
        edges(1'b0, 1'b0);
        chk(penStrobe, 1'b1);
        bus(1'b1, 2'h0, 8'h30);
        bus(1'b1, 2'h0, 8'hB0);
        bus(1'b0, 2'h0, 8'h00);
        edges(1'b0, 1'b1);
        bus(1'b0, 2'h1, 8'h00);
        chk({portaIrqN, got}, 9'h05F);
        edges(1'b0, 1'b0);
        bus(1'b1, 2'h0, 8'h90);
        bus(1'b1, 2'h0, 8'hB0);
        bus(1'b0, 2'h0, 8'h00);
        chk({portaIrqN, irq}, 2'b10);
        // Enables off but rising edge kept: the flag must still set
        bus(1'b1, 2'h1, 8'h14);
        edges(1'b0, 1'b1);
        bus(1'b0, 2'h1, 8'h00);
        chk({portaIrqN, got}, 9'h154);
        report_and_stop();
    end
endmodule // printer_pen_retrace_port_tb
